// ### hdl/tss_prescaler.sv
// Scan clock prescaler: one-cycle tick every 2**prescale reference clocks.
`timescale 1ns/10ps
`default_nettype none
module tss_prescaler
(
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    // Control
    input  wire logic                     run,
    input  wire logic [tss_pkg::PS_W-1:0] prescale,
    // Tick out
    output logic                          tick_r
);
    localparam int PSC_W = tss_pkg::PSC_W;

    logic [tss_pkg::PSC_W-1:0] cnt_r;
    logic [tss_pkg::PSC_W-1:0] last;

    // At the top setting the shift wraps to zero, so last becomes all ones.
    assign last = PSC_W'((tss_pkg::PSC_ONE << prescale) - tss_pkg::PSC_ONE);

    // Counter restarts whenever the sequencer leaves the inactive phase,
    // so every inactive phase begins with a full prescaler period.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_r  <= tss_pkg::PSC_ZERO;
            tick_r <= 1'b0;
        end
        else if (!run)
        begin
            cnt_r  <= tss_pkg::PSC_ZERO;
            tick_r <= 1'b0;
        end
        else if (cnt_r == last)
        begin
            cnt_r  <= tss_pkg::PSC_ZERO;
            tick_r <= 1'b1;
        end
        else
        begin
            cnt_r  <= PSC_W'(cnt_r + tss_pkg::PSC_ONE);
            tick_r <= 1'b0;
        end
    end
endmodule : tss_prescaler
`default_nettype wire

// ### hdl/tss_sequencer.sv
// Touch scan interval sequencer: electrode stepping, inactive phase, flags.
`timescale 1ns/10ps
`default_nettype none
module tss_sequencer
#(
    parameter int RESULT_DELAY_CYC = tss_pkg::RESULT_DELAY_CYC
)
(
    // Clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           resetn,
    // Configuration
    input  wire logic                           continuous_en,
    input  wire logic [tss_pkg::IDLE_MOD_W-1:0] scan_idle_modulus,
    input  wire logic [tss_pkg::PS_W-1:0]       scan_clock_prescale,
    input  wire logic [tss_pkg::NUM_ELEC-1:0]   electrode_enable,
    input  wire logic [tss_pkg::VAL_W-1:0]      threshold_low,
    input  wire logic [tss_pkg::VAL_W-1:0]      threshold_high,
    input  wire logic                           eos_irq_en,
    input  wire logic                           oor_irq_en,
    // Software control strobes
    input  wire logic                           soft_scan_trigger_set,
    input  wire logic                           eos_flag_clear,
    input  wire logic                           oor_flag_clear,
    // Result readback
    input  wire logic [tss_pkg::IDX_W-1:0]      result_index,
    output logic      [tss_pkg::VAL_W-1:0]      result_data_r,
    // Measurement front end
    output logic                                meas_start_r,
    output logic      [tss_pkg::IDX_W-1:0]      meas_sel_r,
    input  wire logic                           meas_done,
    input  wire logic [tss_pkg::VAL_W-1:0]      meas_value,
    // Status
    output logic                                soft_scan_trigger_r,
    output logic                                scan_busy_r,
    output logic                                end_of_scan_flag_r,
    output logic                                out_of_range_flag_r,
    output logic                                eos_irq_r,
    output logic                                oor_irq_r
);
    localparam int NE    = tss_pkg::NUM_ELEC;
    localparam int IW    = tss_pkg::IDX_W;
    localparam int VW    = tss_pkg::VAL_W;
    localparam int SW    = tss_pkg::IDLE_MOD_W;
    localparam int DW    = tss_pkg::DLY_W;
    localparam logic [DW-1:0] DLY_LAST = DW'(RESULT_DELAY_CYC - 1);

    tss_pkg::tss_state_t state_r;
    tss_pkg::tss_state_t state_nxt;

    logic [VW-1:0] scan_buf_r  [NE];
    logic [VW-1:0] pending_r   [NE];
    logic [VW-1:0] visible_r   [NE];
    logic [NE-1:0] pend_mask_r;
    logic [SW-1:0] idle_cnt_r;
    logic [DW-1:0] dly_cnt_r;
    logic          dly_run_r;
    logic          scan_end;
    logic          start_scan;
    logic          publish;
    logic          idle_tick;
    logic          rest_done;
    logic          first_ok;
    logic [IW-1:0] first_idx;
    logic          next_ok;
    logic [IW-1:0] next_idx;
    logic          any_oor;
    logic          psc_tick;

    // Lowest enabled electrode at or above a start index.
    function automatic logic [IW:0] find_from(input logic [NE-1:0] mask,
                                              input logic [IW:0]   from);
        logic [IW:0] res;
        res = {1'b0, tss_pkg::IDX_ZERO};
        for (int i = NE - 1; i >= 0; i--)
        begin
            if (mask[i] && (IW+1)'(i) >= from)
            begin
                res = {1'b1, IW'(i)};
            end
        end
        return res;
    endfunction : find_from

    // True when a value lies outside the threshold window.
    function automatic logic outside(input logic [VW-1:0] v,
                                     input logic [VW-1:0] lo,
                                     input logic [VW-1:0] hi);
        return (v < lo) || (v > hi);
    endfunction : outside

    assign {first_ok, first_idx} = find_from(electrode_enable, {1'b0, tss_pkg::IDX_ZERO});
    assign {next_ok, next_idx}   = (meas_sel_r == tss_pkg::IDX_LAST) ? {1'b0, tss_pkg::IDX_ZERO}
        : find_from(electrode_enable, (IW+1)'({1'b0, meas_sel_r} + 1'b1));

    // A single scan request is honoured only from idle; while busy it is dropped.
    assign start_scan = (state_r == tss_pkg::TSS_IDLE)
                        && (soft_scan_trigger_r || continuous_en);

    // Scan completes when the last enabled electrode returns its count, or
    // at once when no electrode is enabled.
    assign scan_end = ((state_r == tss_pkg::TSS_WAIT) && meas_done && !next_ok)
                      || ((state_r == tss_pkg::TSS_REQ) && !first_ok);

    assign idle_tick = (state_r == tss_pkg::TSS_REST) && psc_tick;
    assign rest_done = idle_tick && (idle_cnt_r == SW'(scan_idle_modulus - 1'b1));

    tss_prescaler u_prescaler
    (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .run      (state_r == tss_pkg::TSS_REST),
        .prescale (scan_clock_prescale),
        .tick_r   (psc_tick)
    );

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            tss_pkg::TSS_IDLE:
                if (start_scan)
                    state_nxt = tss_pkg::TSS_REQ;
            tss_pkg::TSS_REQ:
                state_nxt = first_ok ? tss_pkg::TSS_WAIT : tss_pkg::TSS_REST;
            tss_pkg::TSS_WAIT:
                if (meas_done)
                    state_nxt = next_ok ? tss_pkg::TSS_WAIT : tss_pkg::TSS_REST;
            tss_pkg::TSS_REST:
                // Software scans and a zero modulus take no pause at all.
                if (!continuous_en || scan_idle_modulus == tss_pkg::IDLE_MOD_ZERO)
                    state_nxt = tss_pkg::TSS_IDLE;
                else if (rest_done)
                    state_nxt = tss_pkg::TSS_IDLE;
            default:
                state_nxt = tss_pkg::TSS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            state_r <= tss_pkg::TSS_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            idle_cnt_r <= tss_pkg::IDLE_MOD_ZERO;
        else if (state_r != tss_pkg::TSS_REST)
            idle_cnt_r <= tss_pkg::IDLE_MOD_ZERO;
        else if (idle_tick)
            idle_cnt_r <= SW'(idle_cnt_r + 1'b1);
    end

    // Front end handshake: one start pulse per electrode.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meas_start_r <= 1'b0;
            meas_sel_r   <= tss_pkg::IDX_ZERO;
        end
        else
        begin
            meas_start_r <= 1'b0;
            if (state_r == tss_pkg::TSS_REQ && first_ok)
            begin
                meas_start_r <= 1'b1;
                meas_sel_r   <= first_idx;
            end
            else if (state_r == tss_pkg::TSS_WAIT && meas_done && next_ok)
            begin
                meas_start_r <= 1'b1;
                meas_sel_r   <= next_idx;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (state_r == tss_pkg::TSS_WAIT && meas_done)
            scan_buf_r[meas_sel_r] <= meas_value;
        if (scan_end)
        begin
            pending_r <= scan_buf_r;
            // The last count arrives on the scan-end edge itself; take it straight in.
            if (state_r == tss_pkg::TSS_WAIT)
                pending_r[meas_sel_r] <= meas_value;
        end
        if (publish)
            visible_r <= pending_r;
        result_data_r <= visible_r[result_index];
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            pend_mask_r <= '0;
        else if (scan_end)
            pend_mask_r <= electrode_enable;
    end

    // Counts stay hidden for the publication latency after end of scan; a
    // later scan ending first restarts the wait, dropping the older set.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dly_run_r <= 1'b0;
            dly_cnt_r <= '0;
        end
        else if (scan_end)
        begin
            dly_run_r <= 1'b1;
            dly_cnt_r <= '0;
        end
        else if (publish)
            dly_run_r <= 1'b0;
        else if (dly_run_r)
            dly_cnt_r <= DW'(dly_cnt_r + 1'b1);
    end

    assign publish = dly_run_r && !scan_end && (dly_cnt_r == DLY_LAST);

    always_comb
    begin
        any_oor = 1'b0;
        for (int i = 0; i < NE; i++)
            if (pend_mask_r[i] && outside(pending_r[i], threshold_low, threshold_high))
                any_oor = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            soft_scan_trigger_r <= 1'b0;
        else if (state_r == tss_pkg::TSS_IDLE && start_scan)
            soft_scan_trigger_r <= 1'b0;
        else if (soft_scan_trigger_set && state_r == tss_pkg::TSS_IDLE)
            soft_scan_trigger_r <= 1'b1;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            scan_busy_r <= 1'b0;
        else
            scan_busy_r <= (state_nxt != tss_pkg::TSS_IDLE);
    end

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            end_of_scan_flag_r <= 1'b0;
        else if (scan_end)
            end_of_scan_flag_r <= 1'b1;
        else if (eos_flag_clear)
            end_of_scan_flag_r <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            out_of_range_flag_r <= 1'b0;
        else if (publish && any_oor)
            out_of_range_flag_r <= 1'b1;
        else if (oor_flag_clear)
            out_of_range_flag_r <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            eos_irq_r <= 1'b0;
            oor_irq_r <= 1'b0;
        end
        else
        begin
            eos_irq_r <= eos_irq_en && (end_of_scan_flag_r || scan_end);
            oor_irq_r <= oor_irq_en && (out_of_range_flag_r || (publish && any_oor));
        end
    end
endmodule : tss_sequencer
`default_nettype wire

// ### shared/tss_pkg.sv
// Constants and types shared by the touch scan interval sequencer.
// Summary of operation
// - After scanning all enabled electrodes, pause in an inactive phase before rescanning.
// - Inactive phase timed by reference clock through prescaler, then idle modulus count.
// - Inactive phase length equals the prescale and idle modulus settings combined.
// - Idle modulus of zero rescans immediately with no pause.
// - Software trigger bit starts exactly one scan of the enabled electrodes.
// - Out-of-range flag and interrupt raised only when a published value lies outside the threshold window.
// - End-of-scan flag and interrupt each scan; results readable about 0.25 ms later.
// - Out-of-range flag and interrupt come only after results are updated.
package tss_pkg;
    localparam int NUM_ELEC = 16;
    localparam int IDX_W    = 4;
    localparam int VAL_W    = 16;
    localparam int IDLE_MOD_W = 8;
    localparam int PS_W     = 3;
    localparam int PSC_W    = 7;

    // Reference clock period and the result publication latency.
    localparam int CLK_PERIOD_NS   = 20;
    localparam int RESULT_DELAY_NS = 250000;
    localparam int RESULT_DELAY_CYC =
        (RESULT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W = 16;

    localparam logic [IDX_W-1:0] IDX_ZERO  = 4'h0;
    localparam logic [IDX_W-1:0] IDX_LAST  = 4'hf;
    localparam logic [IDLE_MOD_W-1:0] IDLE_MOD_ZERO = 8'h00;
    localparam logic [VAL_W-1:0] VAL_ZERO  = 16'h0000;
    localparam logic [PSC_W-1:0] PSC_ZERO  = 7'h00;
    localparam logic [PSC_W-1:0] PSC_ONE   = 7'h01;

    typedef enum logic [3:0] {
        TSS_IDLE = 4'b0001,
        TSS_REQ  = 4'b0010,
        TSS_WAIT = 4'b0100,
        TSS_REST = 4'b1000
    } tss_state_t;
endpackage : tss_pkg

// ### testbench/testbench.sv
// Self-checking bench for the touch scan interval sequencer.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int DLY = 20;
    logic        ref_clk, resetn, continuous_en, eos_irq_en, oor_irq_en, stat_clr;
    logic        soft_scan_trigger_set, eos_flag_clear, oor_flag_clear, meas_start_r;
    logic        soft_scan_trigger_r, scan_busy_r, end_of_scan_flag_r, out_of_range_flag_r;
    logic        eos_irq_r, oor_irq_r;
    logic [7:0]  scan_idle_modulus;
    logic [2:0]  scan_clock_prescale;
    logic [3:0]  result_index, meas_sel_r;
    logic [15:0] electrode_enable, threshold_low, threshold_high, result_data_r;
    // The front-end model is the only process that drives meas_done to n_starts after time zero.
    logic        meas_done  = 1'b0;
    logic [1:0]  dly        = 2'h0;
    logic [15:0] meas_value = 16'h0000;
    logic [15:0] gap        = 16'h0000;
    logic [15:0] max_gap    = 16'h0000;
    logic [15:0] n_starts   = 16'h0000;
    logic [15:0] vals [16];
    int          fail_count = 0;
    int          n_tests = 0;

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    tss_sequencer #(.RESULT_DELAY_CYC(DLY)) dut
    (
        .ref_clk, .resetn, .continuous_en, .scan_idle_modulus, .scan_clock_prescale,
        .electrode_enable, .threshold_low, .threshold_high, .eos_irq_en, .oor_irq_en,
        .soft_scan_trigger_set, .eos_flag_clear, .oor_flag_clear, .result_index,
        .result_data_r, .meas_start_r, .meas_sel_r, .meas_done, .meas_value,
        .soft_scan_trigger_r, .scan_busy_r, .end_of_scan_flag_r, .out_of_range_flag_r,
        .eos_irq_r, .oor_irq_r
    );

    // Front end answers each start three cycles later; the value line toggles when idle.
    always @(posedge ref_clk)
    begin
        meas_done  <= 1'b0;
        meas_value <= ~meas_value;
        gap        <= gap + 16'h0001;
        if (meas_start_r)
        begin
            dly      <= 2'h3;
            n_starts <= n_starts + 16'h0001;
            if (gap > max_gap)
                max_gap <= gap;
        end
        else if (dly != 2'h0)
            dly <= dly - 2'h1;
        if (dly == 2'h1)
        begin
            meas_done  <= 1'b1;
            meas_value <= vals[meas_sel_r];
            gap        <= 16'h0000;
        end
        if (stat_clr)
        begin
            n_starts <= 16'h0000;
            max_gap  <= 16'h0000;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    task automatic wait_idle;
        int i;
        for (i = 0; i < 3000 && scan_busy_r !== 1'b0; i++)
            tick(1);
        if (i == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    endtask : wait_idle

    task automatic strobe(input logic trig, input logic eclr, input logic oclr, input logic sclr);
        soft_scan_trigger_set <= trig;
        eos_flag_clear        <= eclr;
        oor_flag_clear        <= oclr;
        stat_clr              <= sclr;
        tick(1);
        soft_scan_trigger_set <= 1'b0;
        eos_flag_clear        <= 1'b0;
        oor_flag_clear        <= 1'b0;
        stat_clr              <= 1'b0;
    endtask : strobe

    task automatic t_single;
        electrode_enable <= 16'h0005;
        strobe(1'b1, 1'b0, 1'b0, 1'b1);
        tick(1);
        check("trigger bit", soft_scan_trigger_r, 16'h1);
        soft_scan_trigger_set <= 1'b1;
        tick(1);
        check("trigger cleared", soft_scan_trigger_r, 16'h0);
        soft_scan_trigger_set <= 1'b0;
        tick(2);
        wait_idle();
        tick(4);
        check("busy", scan_busy_r, 16'h0);
        check("starts", n_starts, 16'h2);
        check("end flag", end_of_scan_flag_r, 16'h1);
        check("end irq", eos_irq_r, 16'h1);
        strobe(1'b0, 1'b1, 1'b0, 1'b0);
        tick(2);
        check("end irq clear", eos_irq_r, 16'h0);
        tick(DLY);
        check("result", result_data_r, vals[0]);
        check("range flag", out_of_range_flag_r, 16'h0);
        $display("single scan test done");
    endtask : t_single

    task automatic t_oor;
        vals[2] <= 16'hf000;
        result_index <= 4'h2;
        strobe(1'b1, 1'b0, 1'b0, 1'b0);
        tick(3);
        wait_idle();
        check("range flag early", out_of_range_flag_r, 16'h0);
        check("range result early", result_data_r, 16'h1000);
        tick(DLY + 4);
        check("range flag", out_of_range_flag_r, 16'h1);
        check("range irq", oor_irq_r, 16'h1);
        check("range result", result_data_r, 16'hf000);
        strobe(1'b0, 1'b1, 1'b1, 1'b0);
        vals[2] <= 16'h1000;
        $display("range test done");
    endtask : t_oor

    task automatic t_interval(input logic [7:0] m, input logic [2:0] ps);
        logic [15:0] lo;
        lo = 16'(m) << ps;
        scan_idle_modulus   <= m;
        scan_clock_prescale <= ps;
        continuous_en       <= 1'b1;
        tick(100);
        strobe(1'b0, 1'b0, 1'b0, 1'b1);
        tick(299);
        check("pause floor", 16'(max_gap >= lo), 16'h1);
        check("pause ceiling", 16'(max_gap <= lo + (16'h1 << ps) + 16'h6), 16'h1);
        continuous_en <= 1'b0;
        tick(2);
        wait_idle();
        $display("interval test done");
    endtask : t_interval

    initial
    begin
        resetn = 1'b0;
        {continuous_en, soft_scan_trigger_set, eos_flag_clear, oor_flag_clear} = 4'h0;
        {eos_irq_en, oor_irq_en, stat_clr} = 3'h6;
        {scan_idle_modulus, scan_clock_prescale, result_index} = 15'h0000;
        electrode_enable = 16'h0000;
        threshold_low  = 16'h0100;
        threshold_high = 16'h8000;
        for (int i = 0; i < 16; i++)
            vals[i] = 16'h1000;
        tick(12);
        resetn <= 1'b1;
        t_single();
        t_oor();
        t_interval(8'h00, 3'h0);
        t_interval(8'h03, 3'h1);
        t_interval(8'h02, 3'h2);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire

// ### testbench/tss_properties.sv
// Port-level assertions for the touch scan interval sequencer.
`timescale 1ns/10ps
`default_nettype none
module tss_properties
#(
    parameter int RESULT_DELAY_CYC = 20
)
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        resetn,
    // Configuration and strobes
    input wire logic        continuous_en,
    input wire logic [7:0]  scan_idle_modulus,
    input wire logic [15:0] electrode_enable,
    input wire logic        eos_irq_en,
    input wire logic        oor_irq_en,
    input wire logic        soft_scan_trigger_set,
    input wire logic        eos_flag_clear,
    // Status
    input wire logic        meas_start_r,
    input wire logic        soft_scan_trigger_r,
    input wire logic        scan_busy_r,
    input wire logic        end_of_scan_flag_r,
    input wire logic        out_of_range_flag_r,
    input wire logic        eos_irq_r,
    input wire logic        oor_irq_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Age of the last rise of the end-of-scan flag; saturates so it never wraps to a small value.
    logic [15:0] since_eos_r;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            since_eos_r <= 16'h0000;
        else if ($rose(end_of_scan_flag_r))
            since_eos_r <= 16'h0001;
        else if (since_eos_r != 16'hffff)
            since_eos_r <= since_eos_r + 16'h0001;
    end

    sequence s_trig_taken;
        soft_scan_trigger_set && !scan_busy_r && !soft_scan_trigger_r ##1 soft_scan_trigger_r;
    endsequence
    sequence s_cont_idle;
        $fell(scan_busy_r) && continuous_en && scan_idle_modulus == 8'h00 ##1 continuous_en;
    endsequence

    property p_trig_set;
        soft_scan_trigger_set && !scan_busy_r && !soft_scan_trigger_r |=> soft_scan_trigger_r;
    endproperty
    a_trig_set: assert property (p_trig_set) else $error("trigger not taken");
    property p_trig_start;
        s_trig_taken ##0 electrode_enable != 16'h0000
            |=> !soft_scan_trigger_r && scan_busy_r ##1 meas_start_r;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("scan not started");
    property p_busy_ignore;
        scan_busy_r && soft_scan_trigger_set |=> !soft_scan_trigger_r;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("busy trigger taken");
    property p_eos_irq;
        $rose(end_of_scan_flag_r) |-> eos_irq_r == $past(eos_irq_en);
    endproperty
    a_eos_irq: assert property (p_eos_irq) else $error("scan end irq wrong");
    property p_oor_irq;
        $rose(out_of_range_flag_r) |-> oor_irq_r == $past(oor_irq_en);
    endproperty
    a_oor_irq: assert property (p_oor_irq) else $error("range irq wrong");
    property p_oor_late;
        $rose(out_of_range_flag_r) |-> since_eos_r >= 16'(RESULT_DELAY_CYC);
    endproperty
    a_oor_late: assert property (p_oor_late) else $error("range flag too early");
    property p_clear;
        eos_flag_clear && !scan_busy_r |=> !end_of_scan_flag_r ##1 !eos_irq_r;
    endproperty
    a_clear: assert property (p_clear) else $error("scan end flag kept");
    property p_rescan0;
        s_cont_idle |-> ##[0:1] scan_busy_r;
    endproperty
    a_rescan0: assert property (p_rescan0) else $error("pause with zero idle");
endmodule : tss_properties

bind tss_sequencer tss_properties #(.RESULT_DELAY_CYC(RESULT_DELAY_CYC)) u_chk
(
    .ref_clk, .resetn, .continuous_en, .scan_idle_modulus, .electrode_enable, .eos_irq_en,
    .oor_irq_en, .soft_scan_trigger_set, .eos_flag_clear, .meas_start_r, .soft_scan_trigger_r,
    .scan_busy_r, .end_of_scan_flag_r, .out_of_range_flag_r, .eos_irq_r, .oor_irq_r
);
`default_nettype wire
